/* rtl/spi_pkg.sv */
// package of constants and types for the switch port interrupt generator
package spi_pkg;
	localparam int NUM_INTX          = 4;
	localparam int DEV_NUM_W         = 5;
	localparam logic [3:0] INTX_RESET = 4'h0;
	localparam logic [1:0] INTA_IDX   = 2'h0;

	typedef enum logic [1:0]
	{
		SPI_MSG_NONE   = 2'b00,
		SPI_MSG_ASSERT = 2'b01,
		SPI_MSG_DEASRT = 2'b10
	} spi_msg_t;

	// remap a downstream intx index by device number
	function automatic logic [1:0] spi_swizzle(input logic [1:0] idx,
		input logic [DEV_NUM_W-1:0] dev);
		spi_swizzle = idx + dev[1:0];
	endfunction : spi_swizzle
endpackage : spi_pkg

/* rtl/spi_port_if.sv */
// carrier between a downstream port engine and the aggregator
`timescale 1ns/100ps
interface spi_port_if;
	logic       wire_a;
	logic       msi_pulse;
	modport port (output wire_a, output msi_pulse);
	modport core (input wire_a, input msi_pulse);
endinterface : spi_port_if

/* rtl/spi_port_engine.sv */
// one downstream port interrupt engine
`timescale 1ns/100ps
module spi_port_engine
	import spi_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// sources
	input  wire logic hp_irq,
	input  wire logic hp_irq_en,
	input  wire logic link_bw_mgmt_status,
	input  wire logic link_auto_bw_status,
	input  wire logic bw_mgmt_irq_en,
	input  wire logic auto_bw_irq_en,
	// enables
	input  wire logic msi_en,
	input  wire logic legacy_irq_disable,
	input  wire logic port_active,
	// to core
	spi_port_if.port  pif
);
	logic cond;
	logic cond_reg;
	logic wire_a_reg;

	// unmasked sources only; masking or clearing removes the condition
	assign cond = port_active & ((hp_irq & hp_irq_en)
		| (link_bw_mgmt_status & bw_mgmt_irq_en)
		| (link_auto_bw_status & auto_bw_irq_en));

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cond_reg <= 1'b0;
		else
			cond_reg <= cond;
	end

	// msi on rising edge when enabled
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pif.msi_pulse <= 1'b0;
		else
			pif.msi_pulse <= cond & ~cond_reg & msi_en;
	end

	// legacy wire uses inta only; negated on link down or removal
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			wire_a_reg <= 1'b0;
		else if (!port_active)
			wire_a_reg <= 1'b0;
		else if (!msi_en && !legacy_irq_disable && cond && !cond_reg)
			wire_a_reg <= 1'b1;
		else if (!msi_en && !legacy_irq_disable && !cond && cond_reg)
			wire_a_reg <= 1'b0;
	end

	assign pif.wire_a = wire_a_reg;
endmodule : spi_port_engine

/* rtl/spi_top.sv */
// switch partition interrupt generator top
// Operation
// - An unmasked interrupt condition at a port yields an msi or a legacy request per enables.
// - The condition ends once every causing unmasked status bit is masked or cleared.
// - Every msi from any port goes to the root through the upstream port.
// - On assertion, msi if enabled, else assert inta unless legacy is disabled.
// - On negation, deassert inta only when msi is off and legacy is enabled.
// - Sources are hot-plug and enabled bandwidth status bits.
// - Legacy mode uses only inta for own interrupts.
// - An aggregated state is kept for each of the four intx signals at the upstream port.
// - Upstream sends assert on a negated-to-asserted aggregate change.
// - Upstream sends deassert on an asserted-to-negated aggregate change.
// - Downstream bridges remap legacy interrupts by device number.
// - Upstream index is downstream index plus device number, modulo four.
// - A device's signal combines external link interrupts and port interrupts.
// - Link down or removal negates all of a port's wires and updates the aggregate.
`timescale 1ns/100ps
module spi_top
	import spi_pkg::*;
#(
	parameter int NUM_DS = 4
)
(
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// downstream port sources
	input  wire logic [NUM_DS-1:0]         hp_irq,
	input  wire logic [NUM_DS-1:0]         hp_irq_en,
	input  wire logic [NUM_DS-1:0]         link_bw_mgmt_status,
	input  wire logic [NUM_DS-1:0]         link_auto_bw_status,
	input  wire logic [NUM_DS-1:0]         bw_mgmt_irq_en,
	input  wire logic [NUM_DS-1:0]         auto_bw_irq_en,
	// downstream port config
	input  wire logic [NUM_DS-1:0]         msi_en,
	input  wire logic [NUM_DS-1:0]         legacy_irq_disable,
	input  wire logic [NUM_DS-1:0]         link_up,
	input  wire logic [NUM_DS-1:0]         in_partition,
	input  wire logic [NUM_DS*DEV_NUM_W-1:0] ds_dev_num,
	// external intx wires received on each downstream link
	input  wire logic [NUM_DS*NUM_INTX-1:0] ds_ext_intx,
	// upstream port own wires
	input  wire logic [NUM_INTX-1:0]       us_own_intx,
	// to root
	output logic                           msi_req,
	output logic [NUM_DS-1:0]              msi_src,
	output logic [NUM_INTX-1:0]            intx_state,
	output logic                           intx_msg_valid,
	output spi_msg_t                       intx_msg_type,
	output logic [1:0]                     intx_msg_idx
);
	spi_port_if          pif [NUM_DS] ();
	logic [NUM_DS-1:0]   wire_a;
	logic [NUM_DS-1:0]   msi_p;
	logic [NUM_INTX-1:0] agg;
	logic [NUM_INTX-1:0] pend;
	logic [1:0]          sel;
	logic                sel_ok;

	for (genvar p = 0; p < NUM_DS; p++)
	begin : g_port
		spi_port_engine u_eng (
			.clk                (clk),
			.rstn               (rstn),
			.hp_irq             (hp_irq[p]),
			.hp_irq_en          (hp_irq_en[p]),
			.link_bw_mgmt_status(link_bw_mgmt_status[p]),
			.link_auto_bw_status(link_auto_bw_status[p]),
			.bw_mgmt_irq_en     (bw_mgmt_irq_en[p]),
			.auto_bw_irq_en     (auto_bw_irq_en[p]),
			.msi_en             (msi_en[p]),
			.legacy_irq_disable (legacy_irq_disable[p]),
			.port_active        (link_up[p] & in_partition[p]),
			.pif                (pif[p])
		);
		assign wire_a[p] = pif[p].wire_a;
		assign msi_p[p]  = pif[p].msi_pulse;
	end

	// aggregate with device swizzle
	always_comb
	begin
		agg = us_own_intx;
		for (int p = 0; p < NUM_DS; p++)
		begin
			if (link_up[p] && in_partition[p])
			begin
				for (int i = 0; i < NUM_INTX; i++)
				begin
					// external and own wires swizzled by device number at the port
					if (ds_ext_intx[p*NUM_INTX+i] || (i == 0 && wire_a[p]))
						agg[spi_swizzle(2'(i), ds_dev_num[p*DEV_NUM_W +: DEV_NUM_W])] = 1'b1;
				end
			end
		end
	end

	// msi forwarded upstream
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			msi_req <= 1'b0;
			msi_src <= '0;
		end
		else
		begin
			msi_req <= |msi_p;
			msi_src <= msi_p;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			intx_state <= INTX_RESET;
		else
			intx_state <= agg;
	end

	// pending changes, one message per cycle, lowest index first
	always_comb
	begin
		sel    = INTA_IDX;
		sel_ok = 1'b0;
		for (int i = NUM_INTX - 1; i >= 0; i--)
		begin
			if (pend[i])
			begin
				sel    = 2'(i);
				sel_ok = 1'b1;
			end
		end
	end

	// sent state tracks what the root has been told
	logic [NUM_INTX-1:0] sent_reg;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sent_reg       <= INTX_RESET;
			intx_msg_valid <= 1'b0;
			intx_msg_type  <= SPI_MSG_NONE;
			intx_msg_idx   <= INTA_IDX;
		end
		else
		begin
			intx_msg_valid <= sel_ok;
			intx_msg_idx   <= sel;
			if (sel_ok)
			begin
				sent_reg[sel] <= intx_state[sel];
				intx_msg_type <= intx_state[sel] ? SPI_MSG_ASSERT : SPI_MSG_DEASRT;
			end
			else
				intx_msg_type <= SPI_MSG_NONE;
		end
	end

	assign pend = intx_state ^ sent_reg;
endmodule : spi_top

/* tb/spi_props.sv */
// checker of the interrupt generator ports
`timescale 1ns/100ps
module spi_props
	import spi_pkg::*;
#(parameter int NUM_DS = 4)
(
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic [NUM_DS-1:0] hp_irq,
	input wire logic [NUM_DS-1:0] hp_irq_en,
	input wire logic [NUM_DS-1:0] link_up,
	input wire logic [NUM_DS-1:0] in_partition,
	input wire logic [NUM_DS-1:0] msi_en,
	input wire logic [NUM_DS-1:0] legacy_irq_disable,
	input wire logic              msi_req,
	input wire logic [3:0]        intx_state,
	input wire logic              intx_msg_valid,
	input wire spi_msg_t          intx_msg_type,
	input wire logic [1:0]        intx_msg_idx
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_up0;
		$rose(hp_irq[0]) && hp_irq_en[0] && link_up[0] && in_partition[0];
	endsequence
	sequence s_ass; intx_msg_valid && intx_msg_type == SPI_MSG_ASSERT; endsequence
	sequence s_dea; intx_msg_valid && intx_msg_type == SPI_MSG_DEASRT; endsequence
	a_msi_on_rise: assert property (s_up0 ##0 msi_en[0] |-> ##2 msi_req)
		else $error("msi late");
	a_no_msi_off: assert property ((msi_en == '0) [*3] |-> !msi_req)
		else $error("msi while off");
	a_legacy_set: assert property (s_up0 ##0 !msi_en[0] && !legacy_irq_disable[0]
		|-> ##2 intx_state != 4'h0)
		else $error("wire not set");
	a_assert_msg: assert property ($rose(intx_state[0]) |-> ##[1:4] s_ass ##0
		intx_msg_idx == 2'h0)
		else $error("assert missing");
	a_deassert_msg: assert property ($fell(intx_state[0]) |-> ##[1:4] s_dea ##0
		intx_msg_idx == 2'h0)
		else $error("deassert missing");
	a_assert_state: assert property (s_ass |->
		|($past(intx_state) & (4'h1 << intx_msg_idx)))
		else $error("assert wrong");
	a_deassert_state: assert property (s_dea |->
		!(|($past(intx_state) & (4'h1 << intx_msg_idx))))
		else $error("deassert wrong");
	a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> !msi_req && !intx_msg_valid
		&& intx_state == 4'h0)
		else $error("busy in reset");
endmodule : spi_props
bind spi_top spi_props #(.NUM_DS(NUM_DS)) i_props (.clk(clk), .rstn(rstn), .hp_irq(hp_irq),
	.hp_irq_en(hp_irq_en), .link_up(link_up), .in_partition(in_partition),
	.msi_en(msi_en), .legacy_irq_disable(legacy_irq_disable), .msi_req(msi_req),
	.intx_state(intx_state), .intx_msg_valid(intx_msg_valid),
	.intx_msg_type(intx_msg_type), .intx_msg_idx(intx_msg_idx));

/* tb/spi_root_model.sv */
// root complex model gathering upstream messages
`timescale 1ns/100ps
module spi_root_model
	import spi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       msi_req,
	input  wire logic       intx_msg_valid,
	input  wire spi_msg_t   intx_msg_type,
	input  wire logic [1:0] intx_msg_idx,
	output logic [3:0]      seen_intx,
	output logic [7:0]      msi_count
);
	// every msi taken as upstream-routed
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			msi_count <= 8'h00;
		else if (msi_req)
			msi_count <= msi_count + 8'h01;
	// wire mirror from messages
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			seen_intx <= 4'h0;
		else if (intx_msg_valid)
			seen_intx[intx_msg_idx] <= (intx_msg_type == SPI_MSG_ASSERT);
endmodule : spi_root_model

/* tb/tb_top.sv */
// testbench of the partition interrupt generator
`timescale 1ns/100ps
module tb_top;
	import spi_pkg::*;
	logic clk = 1'b1;
	logic rstn = 1'b1;
	logic [3:0] hp, hpe, bws, abs, bwe, abe, msi, dis, lup, inp, msrc, st, seen, own;
	logic [19:0] dev;
	logic [15:0] ext;
	logic msi_req, mval;
	spi_msg_t mtyp;
	logic [1:0] midx;
	logic [7:0] mcnt, c0;
	int failures = 0;
	int tests_run = 0;
	// msi, disable, device, state, msi count
	logic [11:0] rows [7] = '{12'h010, 12'h120, 12'h240, 12'h380, 12'h901, 12'h400, 12'he01};
	spi_top #(.NUM_DS(4)) i_dut (.clk(clk), .rstn(rstn), .hp_irq(hp), .hp_irq_en(hpe),
		.link_bw_mgmt_status(bws), .link_auto_bw_status(abs), .bw_mgmt_irq_en(bwe),
		.auto_bw_irq_en(abe), .msi_en(msi), .legacy_irq_disable(dis), .link_up(lup),
		.in_partition(inp), .ds_dev_num(dev), .ds_ext_intx(ext), .us_own_intx(own),
		.msi_req(msi_req), .msi_src(msrc), .intx_state(st), .intx_msg_valid(mval),
		.intx_msg_type(mtyp), .intx_msg_idx(midx));
	spi_root_model i_root (.clk(clk), .rstn(rstn), .msi_req(msi_req), .intx_msg_valid(mval),
		.intx_msg_type(mtyp), .intx_msg_idx(midx), .seen_intx(seen), .msi_count(mcnt));
	always #4 clk = ~clk;
	task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp_v);
		tests_run++;
		if (seen_v !== exp_v)
		begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic wrap_up;
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	initial
	begin
		{hp, hpe, bws, abs, bwe, abe, msi, dis, ext, own, dev} = '0;
		{lup, inp} = 8'hff;
		cyc(1);
		rstn = 1'b0;
		cyc(16);
		rstn = 1'b1;
		chk({st, seen}, 8'h00);
		hpe[0] = 1'b1;
		foreach (rows[i])
		begin
			{msi[0], dis[0]} = rows[i][11:10];
			dev[4:0] = {3'h0, rows[i][9:8]};
			c0 = mcnt;
			cyc(2);
			hp[0] = 1'b1;
			cyc(2);
			chk({4'h0, msrc}, {4'h0, rows[i][3:0]});
			cyc(4);
			chk({st, seen}, {2{rows[i][7:4]}});
			chk(mcnt - c0, {4'h0, rows[i][3:0]});
			hp[0] = 1'b0;
			cyc(6);
			chk({st, seen}, 8'h00);
			chk(mcnt - c0, {4'h0, rows[i][3:0]});
		end
		{msi, dis, dev, bws} = 32'h4;
		cyc(6);
		chk({st, seen}, 8'h00);
		{bwe[2], abs[2], abe[2]} = 3'h4;
		cyc(6);
		chk({st, seen}, 8'h11);
		{bwe[2], abs[2], abe[2]} = 3'h3;
		cyc(6);
		chk({st, seen}, 8'h11);
		abs[2] = 1'b0;
		cyc(6);
		chk({st, seen}, 8'h00);
		{dev, ext, own} = {20'h38020, 16'h4080, 4'h8};
		cyc(6);
		chk({st, seen}, 8'hbb);
		lup[1] = 1'b0;
		cyc(6);
		chk({st, seen}, 8'haa);
		inp[3] = 1'b0;
		cyc(6);
		chk({st, seen}, 8'h88);
		rstn = 1'b0;
		cyc(2);
		chk({st, seen}, 8'h00);
		rstn = 1'b1;
		cyc(6);
		chk({st, seen}, 8'h88);
		wrap_up();
	end
	initial
	begin
		#20000;
		failures++;
		wrap_up();
	end
endmodule : tb_top
